// ===== rtl/qgi_int_status.sv
// Global interrupt status word: per-channel summary bits and prioritised source codes
//
// Overview of operation
// R1: Summary bit n is one while channel n has a request outstanding.
// R2: Transmitter, receiver, line or modem requests of a channel set its summary bit.
// R3: Summary byte bits 7 to 4 always read zero.
// R4: Summary bit drops once the clearing register read has removed the channel's sources.
// R5: Three-bit source code per channel, channel 0 at bits 10:8, channel 3 at 19:17.
// R6: Status word bits 31 to 20 always read zero.
// R7: Code 1 receive data or line error, 2 receive time-out, 3 transmit empty.
// R8: Code 4 modem, handshake, Xon/Xoff or special character; code 5 never shown.
// R9: Codes 6 pin events and 7 timer appear only in channel 0.
// R10: With several sources pending the lowest code shows; others appear after clearing.
// R11: Summary and all four codes are read together in one dword read.
// R12: Whole status word is zero after reset.
// R13: Waking after all four channels slept raises a host-visible special interrupt.
// R14: Receive data request stays while the FIFO level is at or above trigger.
// R15: Receive time-out request clears only when the receive FIFO is empty.
// R16: Line error request clears on a read of the line status register.
// R17: Transmit ready request clears on a read of the ident register.
// R18: Modem and handshake delta requests clear on a read of the modem status register.
// R19: Xon/Xoff and special character requests clear on a read of the ident register.
// R20: Timer request clears on a read of the timer control register.
// R21: Pin request clears on a read of the pin level register.
// R22: Status bytes sit read-only at offsets 0x080 to 0x083, summary lowest.
`include "qgi_consts.svh"

module qgi_int_status
	import qgi_pkg::*;
#(
	parameter int NUM_CH = `QGI_MAX_CH
)
(
	input  wire logic                     sys_clk,
	input  wire logic                     arst_n,
	input  wire logic                     clkEn,
	input  wire logic [`QGI_ADDR_W-1:0]   regAddr,
	input  wire logic                     regRd,
	input  wire logic [`QGI_BYTES-1:0]    regByteEn,
	output wire logic [31:0]              regRdData,
	output wire logic                     regRdValid,
	output wire logic [31:0]              statusWord,
	input  wire logic [NUM_CH-1:0]        rxAboveTrig,
	input  wire logic [NUM_CH-1:0]        rxFifoEmpty,
	input  wire logic [NUM_CH-1:0]        rxTimeoutEvt,
	input  wire logic [NUM_CH-1:0]        lineErrEvt,
	input  wire logic [NUM_CH-1:0]        txEmptyEvt,
	input  wire logic [NUM_CH-1:0]        modemDeltaEvt,
	input  wire logic [NUM_CH-1:0]        xonSpecialEvt,
	input  wire logic [NUM_CH-1:0]        lineStatusRead,
	input  wire logic [NUM_CH-1:0]        identRead,
	input  wire logic [NUM_CH-1:0]        modemStatusRead,
	input  wire logic                     timerEvt,
	input  wire logic                     timerControlRead,
	input  wire logic                     pinEvt,
	input  wire logic                     pinLevelRead,
	input  wire logic                     allAsleep,
	input  wire logic                     wakeEvt
);

	// Refuse channel counts the 32-bit layout cannot hold
	if (NUM_CH < 1 || NUM_CH > `QGI_MAX_CH)
	begin : g_bad_ch
		$error("qgi_int_status: NUM_CH must be 1 to 4");
	end

	// All state of the block except the two reset synchroniser flip-flops
	typedef struct packed {
		logic [NUM_CH-1:0] lineErr;
		logic [NUM_CH-1:0] rxTimeout;
		logic [NUM_CH-1:0] txEmpty;
		logic [NUM_CH-1:0] modemDelta;
		logic [NUM_CH-1:0] xonSpecial;
		logic              timerPend;
		logic              pinPend;
		qgi_sleep_t        sleepState;
		logic [31:0]       statusWord;
		logic [31:0]       rdData;
		logic              rdValid;
	} qgi_state_t;

	localparam qgi_state_t STATE_RST = '{sleepState: QGI_SLP_AWAKE, default: '0};

	logic       rstMeta_n_r;
	logic       rstSync_n_r;
	qgi_state_t state_r;
	qgi_state_t state_nxt;

	// Priority encoder of one channel's pending sources
	function automatic qgi_code_t srcCode(
		input logic rxData,
		input logic rxTmo,
		input logic txEmp,
		input logic modem,
		input logic pins,
		input logic timer
	);
		if (rxData)
			return `QGI_CODE_RXDATA;                // [R7] [R10]
		else if (rxTmo)
			return `QGI_CODE_RXTMO;                 // [R7]
		else if (txEmp)
			return `QGI_CODE_TXEMPTY;               // [R7]
		else if (modem)
			return `QGI_CODE_MODEM;                 // [R8]
		else if (pins)
			return `QGI_CODE_PINS;                  // [R9]
		else if (timer)
			return `QGI_CODE_TIMER;                 // [R9]
		else
			return `QGI_CODE_NONE;                  // [R8]
	endfunction

	// Reset release through two flip-flops
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rstMeta_n_r <= 1'b0;
			rstSync_n_r <= 1'b0;
		end
		else
		begin
			rstMeta_n_r <= 1'b1;
			rstSync_n_r <= rstMeta_n_r;
		end
	end

	// Next state: pending flags, wake tracking, status word and read port
	always_comb
	begin
		logic [31:0] status;
		qgi_code_t   code;
		logic        woke;
		status = `QGI_STATUS_RST;
		code = `QGI_CODE_NONE;
		woke = 1'b0;
		state_nxt = state_r;
		state_nxt.rdValid = 1'b0;

		// Sticky source flags, a new event wins over a clearing read
		for (int i = 0; i < NUM_CH; i++)
		begin
			state_nxt.lineErr[i]    = lineErrEvt[i] | (state_r.lineErr[i] & ~lineStatusRead[i]);      // [R16]
			state_nxt.rxTimeout[i]  = rxTimeoutEvt[i] | (state_r.rxTimeout[i] & ~rxFifoEmpty[i]);     // [R15]
			state_nxt.txEmpty[i]    = txEmptyEvt[i] | (state_r.txEmpty[i] & ~identRead[i]);           // [R17]
			state_nxt.modemDelta[i] = modemDeltaEvt[i] | (state_r.modemDelta[i] & ~modemStatusRead[i]); // [R18]
			state_nxt.xonSpecial[i] = xonSpecialEvt[i] | (state_r.xonSpecial[i] & ~identRead[i]);     // [R19]
		end

		// Device-level sources kept for channel 0
		state_nxt.timerPend = timerEvt | (state_r.timerPend & ~timerControlRead);                     // [R20]
		state_nxt.pinPend   = pinEvt | (state_r.pinPend & ~pinLevelRead);                             // [R21]

		// Wake-up after all channels slept, cleared by channel 0 ident read
		case (state_r.sleepState)
			QGI_SLP_AWAKE:
			begin
				if (allAsleep)
					state_nxt.sleepState = QGI_SLP_ASLEEP;
			end
			QGI_SLP_ASLEEP:
			begin
				if (wakeEvt)
					state_nxt.sleepState = QGI_SLP_WOKE;    // [R13]
				else if (!allAsleep)
					state_nxt.sleepState = QGI_SLP_AWAKE;
			end
			QGI_SLP_WOKE:
			begin
				if (identRead[0])
					state_nxt.sleepState = QGI_SLP_AWAKE;
			end
			default:
			begin
				state_nxt.sleepState = QGI_SLP_AWAKE;
			end
		endcase
		woke = (state_r.sleepState == QGI_SLP_WOKE);

		// Assemble summary byte and source codes, reserved bits stay zero
		for (int i = 0; i < NUM_CH; i++)
		begin
			code = srcCode(rxAboveTrig[i] | state_r.lineErr[i],                   // [R14]
				state_r.rxTimeout[i],
				state_r.txEmpty[i],
				state_r.modemDelta[i] | state_r.xonSpecial[i],
				(i == 0) ? state_r.pinPend : 1'b0,                            // [R9]
				(i == 0) ? state_r.timerPend : 1'b0);
			status[`QGI_CODE_LSB + i * `QGI_CODE_W +: `QGI_CODE_W] = code;        // [R5]
			status[`QGI_SUM_LSB + i] = (code != `QGI_CODE_NONE) | ((i == 0) & woke); // [R1] [R2] [R4] [R13]
		end
		state_nxt.statusWord = status;                                          // [R3] [R6]

		// Read port: dword at 0x080, byte lanes by enable, other addresses read zero
		if (regRd)
		begin
			state_nxt.rdValid = 1'b1;
			for (int b = 0; b < `QGI_BYTES; b++)
			begin
				if (regByteEn[b] && regAddr[`QGI_ADDR_W-1:2] == `QGI_INT_DWORD)  // [R22]
					state_nxt.rdData[b * `QGI_BYTE_W +: `QGI_BYTE_W] =
						state_r.statusWord[b * `QGI_BYTE_W +: `QGI_BYTE_W];    // [R11]
				else
					state_nxt.rdData[b * `QGI_BYTE_W +: `QGI_BYTE_W] = `QGI_BYTE_ZERO;
			end
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge sys_clk or negedge rstSync_n_r)
	begin
		if (!rstSync_n_r)
			state_r <= STATE_RST;                                               // [R12]
		else if (clkEn)
			state_r <= state_nxt;
	end

	// Outputs straight from the state register
	assign regRdData  = state_r.rdData;
	assign regRdValid = state_r.rdValid;
	assign statusWord = state_r.statusWord;

	// Named sequences used by the checks below
	sequence rdFullDword;
		clkEn && regRd && regAddr[`QGI_ADDR_W-1:2] == `QGI_INT_DWORD && regByteEn == 4'hf;
	endsequence

	sequence asleepThenWake;
		clkEn && state_r.sleepState == QGI_SLP_ASLEEP && wakeEvt;
	endsequence

	sequence lineErrCleared;
		clkEn && lineStatusRead[0] && !lineErrEvt[0];
	endsequence

	sequence wokeThenIdent;
		clkEn && state_r.sleepState == QGI_SLP_WOKE && identRead[0];
	endsequence

	sequence asleepLeftEarly;
		clkEn && state_r.sleepState == QGI_SLP_ASLEEP && !wakeEvt && !allAsleep;
	endsequence

	sequence rdUnmapped;
		clkEn && regRd && regAddr[`QGI_ADDR_W-1:2] != `QGI_INT_DWORD;
	endsequence

	// Reserved bits never set
	a_rsvd_bits_zero: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R3] [R6]
		statusWord[`QGI_RSVD_HI_LSB +: `QGI_RSVD_HI_W] == 12'h000
		&& statusWord[`QGI_RSVD_LO_LSB +: `QGI_RSVD_LO_W] == 4'h0)
		else $error("reserved status bits not zero");

	// Status word zero right at reset release
	a_reset_word_zero: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R12]
		$rose(rstSync_n_r) |-> statusWord == `QGI_STATUS_RST && !regRdValid)
		else $error("status word not zero after reset");

	// Dword read answers next cycle with the word as it stood
	a_dword_read_data: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R11]
		rdFullDword |=> regRdValid && regRdData == $past(statusWord))
		else $error("dword read returned wrong data");

	// Receive data level shows as code 1 one cycle later
	a_rxdata_code_one: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R7] [R14]
		clkEn && rxAboveTrig[0] |=> statusWord[`QGI_CODE_LSB +: `QGI_CODE_W] == `QGI_CODE_RXDATA
		&& statusWord[`QGI_SUM_LSB])
		else $error("receive data not reported as code 1");

	// Line error clears on its read, unless a new error arrives
	a_line_err_clear: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R16]
		lineErrCleared |=> !state_r.lineErr[0])
		else $error("line error not cleared by status read");

	a_line_err_setwins: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R16]
		clkEn && lineErrEvt[0] |=> state_r.lineErr[0])
		else $error("line error event lost");

	// Time-out holds while the FIFO is not empty
	a_rx_tmo_hold: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R15]
		clkEn && state_r.rxTimeout[0] && !rxFifoEmpty[0] |=> state_r.rxTimeout[0])
		else $error("receive time-out cleared early");

	// Timer request clears on timer control read
	a_timer_clear: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R20]
		clkEn && timerControlRead && !timerEvt |=> !state_r.timerPend)
		else $error("timer request not cleared");

	// Summary bit of channel 1 follows its code field
	a_summary_matches: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R1] [R2] [R4]
		statusWord[`QGI_SUM_LSB + 1] == (statusWord[`QGI_CODE_LSB + `QGI_CODE_W +: `QGI_CODE_W] != `QGI_CODE_NONE))
		else $error("summary bit disagrees with source code");

	// Codes 5, 6 and 7 never outside channel 0; code 5 nowhere
	a_rsvd_codes: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R8] [R9]
		statusWord[`QGI_CODE_LSB +: `QGI_CODE_W] != `QGI_CODE_RSVD
		&& statusWord[`QGI_CODE_LSB + `QGI_CODE_W +: `QGI_CODE_W] < `QGI_CODE_RSVD
		&& statusWord[`QGI_CODE_LSB + 2 * `QGI_CODE_W +: `QGI_CODE_W] < `QGI_CODE_RSVD
		&& statusWord[`QGI_CODE_LSB + 3 * `QGI_CODE_W +: `QGI_CODE_W] < `QGI_CODE_RSVD)
		else $error("reserved source code reported");

	// Wake after sleep raises the special summary bit two cycles on
	a_wake_special: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R13]
		asleepThenWake ##1 clkEn |=> statusWord[`QGI_SUM_LSB])
		else $error("wake-up special interrupt missing");

	// Receive time-out clears once the FIFO reads empty
	a_rx_tmo_clear: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R15]
		clkEn && rxFifoEmpty[0] && !rxTimeoutEvt[0] |=> !state_r.rxTimeout[0])
		else $error("receive time-out not cleared by empty FIFO");

	// Transmit ready clears on an ident register read
	a_tx_ready_clear: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R17]
		clkEn && identRead[0] && !txEmptyEvt[0] |=> !state_r.txEmpty[0])
		else $error("transmit ready not cleared by ident read");

	// Modem and handshake deltas clear on a modem status read
	a_modem_clear: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R18]
		clkEn && modemStatusRead[0] && !modemDeltaEvt[0] |=> !state_r.modemDelta[0])
		else $error("modem delta not cleared by modem status read");

	// Xon/Xoff and special character requests clear on an ident read
	a_xon_clear: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R19]
		clkEn && identRead[0] && !xonSpecialEvt[0] |=> !state_r.xonSpecial[0])
		else $error("flow character request not cleared by ident read");

	// Pin request clears on a pin level read
	a_pin_clear: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R21]
		clkEn && pinLevelRead && !pinEvt |=> !state_r.pinPend)
		else $error("pin request not cleared");

	// Time-out shows as code 2 once no receive data or line error is pending
	a_tmo_priority: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R7] [R10]
		clkEn && !rxAboveTrig[0] && !state_r.lineErr[0] && state_r.rxTimeout[0]
		|=> statusWord[`QGI_CODE_LSB +: `QGI_CODE_W] == `QGI_CODE_RXTMO)
		else $error("time-out not shown below receive data priority");

	// Ident read of channel 0 ends the wake-up special interrupt
	a_wake_clear: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R13]
		wokeThenIdent |=> state_r.sleepState == QGI_SLP_AWAKE)
		else $error("wake-up interrupt not cleared by ident read");

	// Leaving sleep without a wake event drops the tracking
	a_sleep_abort: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R13]
		asleepLeftEarly |=> state_r.sleepState == QGI_SLP_AWAKE)
		else $error("sleep tracking kept after channels left sleep");

	// Reads outside the status dword answer zero
	a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R22]
		rdUnmapped |=> regRdValid && regRdData == `QGI_STATUS_RST)
		else $error("unmapped read returned data");

	// Valid stands only for the cycle after a taken read
	a_valid_single: assert property (@(posedge sys_clk) disable iff (!rstSync_n_r) // [R11]
		clkEn && !regRd |=> !regRdValid)
		else $error("read valid without a read");

endmodule // qgi_int_status

// ===== rtl/qgi_consts.svh
// Constants for the global interrupt status word of the quad UART
`ifndef QGI_CONSTS_SVH
`define QGI_CONSTS_SVH

// Channel count that the status word layout can hold
`define QGI_MAX_CH        4

// Status word sits in the dword at byte offsets 0x080..0x083 (address bits 7:2)
`define QGI_INT_DWORD     6'h20
`define QGI_ADDR_W        8
`define QGI_BYTES         4
`define QGI_BYTE_W        8

// Field layout of the status word
`define QGI_SUM_LSB       0
`define QGI_CODE_LSB      8
`define QGI_CODE_W        3
`define QGI_RSVD_LO_LSB   4
`define QGI_RSVD_LO_W     4
`define QGI_RSVD_HI_LSB   20
`define QGI_RSVD_HI_W     12

// Reset values
`define QGI_STATUS_RST    32'h0000_0000
`define QGI_BYTE_ZERO     8'h00

// Source codes, lower code ranks higher
`define QGI_CODE_NONE     3'h0
`define QGI_CODE_RXDATA   3'h1
`define QGI_CODE_RXTMO    3'h2
`define QGI_CODE_TXEMPTY  3'h3
`define QGI_CODE_MODEM    3'h4
`define QGI_CODE_RSVD     3'h5
`define QGI_CODE_PINS     3'h6
`define QGI_CODE_TIMER    3'h7

`endif

// ===== rtl/qgi_pkg.sv
// Types shared by the global interrupt status logic
package qgi_pkg;

	// Source code of one channel field
	typedef logic [2:0] qgi_code_t;

	// Tracking of the all-channels-asleep wake-up condition
	typedef enum logic [2:0]
	{
		QGI_SLP_AWAKE  = 3'b001,
		QGI_SLP_ASLEEP = 3'b010,
		QGI_SLP_WOKE   = 3'b100
	} qgi_sleep_t;

endpackage

// ===== verif/qgi_host_model.sv
// Host-side model that issues reads of the status dword
module qgi_host_model (
	input  wire logic        sys_clk,
	input  wire logic        regRdValid,
	input  wire logic [31:0] regRdData,
	output logic      [7:0]  regAddr,
	output logic             regRd,
	output logic      [3:0]  regByteEn
);
	timeunit 1ns;
	timeprecision 1ns;

	int rdLat;

	// Idle bus at time zero
	initial
	begin
		rdLat = 0;
		regRd = 1'b0;
		regAddr = 8'h00;
		regByteEn = 4'h0;
	end

	// One read: request for one cycle, data taken at the edge that samples valid
	task automatic rd(input logic [7:0] a, input logic [3:0] b, output logic [31:0] d);
		int n;
		@(posedge sys_clk);
		regRd <= 1'b1;
		regAddr <= a;
		regByteEn <= b;
		@(posedge sys_clk);
		regRd <= 1'b0;
		regAddr <= ~a; // Released lines do not keep the last value
		regByteEn <= ~b;
		for (n = 0; n < 4 && regRdValid !== 1'b1; n++)
			@(posedge sys_clk);
		rdLat = n; // Edges from the taken request to valid seen
		d = regRdData;
	endtask
endmodule // qgi_host_model

// ===== verif/qgi_int_status_tb.sv
// Self-checking bench for the global interrupt status word
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
$display("ERROR %0t: got %h exp %h", $time, a, b); end end
module qgi_int_status_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        clkEn = 1'b1;
	logic        allAsleep = 1'b0;
	logic [3:0]  rxAbove = 4'h0;
	logic [3:0]  sig [11] = '{default: 4'h0};
	logic [7:0]  regAddr;
	logic [3:0]  regByteEn;
	logic        regRd;
	logic        regRdValid;
	logic [31:0] regRdData;
	logic [31:0] statusWord;
	logic [31:0] rdat;
	logic [31:0] seed = 32'h4213_04ca;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          ch;
	int          codeOf [5] = '{2, 1, 3, 4, 4};
	int          clrOf [5] = '{5, 6, 7, 8, 7};

	// Clock and timeout
	initial
	begin
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_fail++;
			summarize();
		end
	end

	qgi_int_status u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .regAddr(regAddr),
		.regRd(regRd), .regByteEn(regByteEn), .regRdData(regRdData), .regRdValid(regRdValid),
		.statusWord(statusWord), .rxAboveTrig(rxAbove), .rxFifoEmpty(sig[5]), .rxTimeoutEvt(sig[0]),
		.lineErrEvt(sig[1]), .txEmptyEvt(sig[2]), .modemDeltaEvt(sig[3]), .xonSpecialEvt(sig[4]),
		.lineStatusRead(sig[6]), .identRead(sig[7]), .modemStatusRead(sig[8]), .timerEvt(sig[9][0]),
		.timerControlRead(sig[9][1]), .pinEvt(sig[9][2]), .pinLevelRead(sig[9][3]),
		.allAsleep(allAsleep), .wakeEvt(sig[10][0]));

	qgi_host_model u_host (.sys_clk(sys_clk), .regRdValid(regRdValid), .regRdData(regRdData),
		.regAddr(regAddr), .regRd(regRd), .regByteEn(regByteEn));

	// Random source and expected word layout
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] word(input int c, input int code, input bit s);
		return (32'(s) << c) | (32'(code) << (8 + 3 * c));
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// One-cycle pulse on bit b of strobe group k
	task automatic pulse(input int k, input int b);
		@(posedge sys_clk);
		sig[k][b] <= 1'b1;
		@(posedge sys_clk);
		sig[k][b] <= 1'b0;
	endtask

	// Compare live word, then a host read at a random byte of the dword with random lanes
	task automatic see(input logic [31:0] e);
		logic [3:0] be;
		tick(2);
		`CHK(statusWord, e)
		seed = lfsr(seed);
		be = seed[3:0];
		u_host.rd({6'h20, seed[5:4]}, be, rdat);
		`CHK(u_host.rdLat, 1)
		`CHK(rdat, e & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}})
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		tick(3);
		see(32'h0000_0000);
		$display("reset test done");
		for (int c = 0; c < 4; c++)
			for (int k = 0; k < 5; k++)
			begin
				pulse(k, c);
				see(word(c, codeOf[k], 1));
				pulse(clrOf[k], c);
				see(32'h0000_0000);
			end
		$display("source test done");
		repeat (4)
		begin
			seed = lfsr(seed);
			ch = int'(seed[1:0]);
			pulse(2, ch);
			pulse(0, ch);
			pulse(1, ch);
			see(word(ch, 1, 1));
			pulse(6, ch);
			see(word(ch, 2, 1));
			pulse(5, ch);
			see(word(ch, 3, 1));
			rxAbove[ch] <= 1'b1;
			pulse(7, ch);
			see(word(ch, 1, 1));
			rxAbove[ch] <= 1'b0;
			see(32'h0000_0000);
		end
		$display("priority test done");
		pulse(9, 0);
		see(word(0, 7, 1));
		pulse(9, 2);
		pulse(3, 1);
		see(word(0, 6, 1) | word(1, 4, 1));
		pulse(9, 3);
		see(word(0, 7, 1) | word(1, 4, 1));
		pulse(9, 1);
		pulse(8, 1);
		see(32'h0000_0000);
		$display("device test done");
		allAsleep <= 1'b1;
		tick(2);
		pulse(10, 0);
		allAsleep <= 1'b0;
		see(32'h0000_0001);
		u_host.rd(8'h84, 4'hf, rdat);
		`CHK(rdat, 32'h0000_0000)
		pulse(7, 0);
		see(32'h0000_0000);
		$display("wake test done");
		allAsleep <= 1'b1;
		tick(2);
		allAsleep <= 1'b0;
		tick(2);
		pulse(10, 0);
		see(32'h0000_0000);
		pulse(1, 0);
		clkEn <= 1'b0;
		pulse(6, 0);
		clkEn <= 1'b1;
		see(word(0, 1, 1));
		pulse(6, 0);
		see(32'h0000_0000);
		$display("enable test done");
		pulse(3, 2);
		arst_n <= 1'b0;
		tick(2);
		`CHK(statusWord, 32'h0000_0000)
		arst_n <= 1'b1;
		tick(3);
		see(32'h0000_0000);
		$display("second reset test done");
		summarize();
	end
endmodule // qgi_int_status_tb
